// *** common/flash_status_defines.vh ***
/*
  Constants for the serial flash status register and write-permission block:
  field positions, instruction codes, frame lengths and timing.
  Assumes inclusion by bare name from design files.
*/
`ifndef FLASH_STATUS_DEFINES_VH
`define FLASH_STATUS_DEFINES_VH

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SR_BUSY_BIT      0
`define SR_WPL_BIT       1
`define SR_PL_LSB        2
`define SR_PL_MSB        5
`define SR_QUAD_BIT      6
`define SR_LOCK_BIT      7
`define SR_NV_LSB        2
`define SR_NV_MSB        7
`define SR_RESET         8'h00

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define CMD_SET_WPL      8'h06
`define CMD_CLR_WPL      8'h04
`define CMD_STATUS_WR    8'h01
`define CMD_STATUS_RD    8'h05
`define CMD_FUNC_RD      8'h48
`define CMD_EXT_RD       8'h81
`define CMD_RESET_EN     8'h66
`define CMD_RESET        8'h99
`define CMD_SUSPEND      8'h75
`define CMD_PAGE_PROG    8'h02
`define CMD_QPROG_A      8'h32
`define CMD_QPROG_B      8'h38
`define CMD_SECT_ER_A    8'hd7
`define CMD_SECT_ER_B    8'h20
`define CMD_BLK32_ER     8'h52
`define CMD_BLK64_ER     8'hd8
`define CMD_ARRAY_ER_A   8'hc7
`define CMD_ARRAY_ER_B   8'h60
`define CMD_FUNC_WR      8'h42
`define CMD_NV_RP        8'h65
`define CMD_NV_ERP       8'h85
`define CMD_IR_ERASE     8'h64
`define CMD_IR_PROG      8'h62
`define CMD_BOOT_WR      8'h15

// ----------------------------------------------------------------
// Frame lengths in serial clock edges
// ----------------------------------------------------------------
`define CNT_W            6
`define CNT_MAX          6'h3f
`define CMD_BITS         6'h08
`define WR_DATA_BITS     6'h10
`define ADDR_BITS        6'h20
`define CMD_LAST         6'h07
`define DATA_LAST        6'h0f
`define ADDR_LAST        6'h1f
`define BLK_MSB          19
`define BLK_LSB          16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define NV_OP_TIME_NS    50000
`define OP_CNT_W         16

`endif

// *** rtl/flash_status_write_protect.v ***
/*
  Status register and write-permission logic of a serial flash behind an SPI
  mode-0 slave port, oversampled by clk. Program, erase and register writes
  are handed to the array as a start pulse; the busy time is timed here.
  Assumes sck is well below clk/4 and srst acts as power-on.
*/
//
// Behaviour
// - Eight-bit status: busy, write latch, four protect bits, quad, lock; reset zero.
// - Busy reads one during program, erase or register write; clears at end.
// - While busy only status reads and resets are taken.
// - Write latch set by its set command, cleared by clear command, reset or op end.
// - Write latch clears automatically when any write operation finishes.
// - Program and erase commands are inhibited unless the write latch is set.
// - Non-volatile register and info-row commands also need the write latch.
// - Volatile read-register settings need no write latch.
// - Protect level selects a region; program or erase inside it is inhibited.
// - Whole-array erase ignored when any protect bit is nonzero.
// - Protect, quad and lock bits change only by status write; srst zeroes them, software and pin resets keep them.
// - Lock set with protect pin low makes status write ignored.
// - Quad bit off: protect and hold pins are control; on: data lines.
// - Status read returns the whole status register.
// - Quad bit or quad-command mode disables the hold/reset select bit.
`include "flash_status_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module flash_status_write_protect #(
  parameter [`OP_CNT_W-1:0] OP_CYCLES =
    (`NV_OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        sck,
  input  wire        cs_n,
  input  wire        si,
  input  wire        wp_n,
  input  wire        hold_n,
  input  wire        hold_reset_select_bit,
  input  wire        quad_cmd_mode,
  output reg         so,
  output reg         so_oe,
  output wire [7:0]  status_register,
  output wire        busy_flag,
  output wire        write_permit_latch,
  output wire        quad_pins_on,
  output wire        hold_pause,
  output wire        pin_reset_req,
  output reg         array_op_start,
  output reg  [7:0]  array_op_code,
  output reg  [23:0] array_op_addr
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  wire [4:0] pins_s;
  reg        sck_d_r;
  reg        cs_d_r;

  // Sck enters inverted so the synchroniser's reset level is its idle low
  sync2 #(.W(5)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({hold_n, wp_n, si, cs_n, ~sck}),
    .q    (pins_s)
  );

  wire sck_s    = ~pins_s[0];
  wire cs_s     = pins_s[1];
  wire si_s     = pins_s[2];
  wire wp_s     = pins_s[3];
  wire hold_s   = pins_s[4];
  wire sck_rise = sck_s & ~sck_d_r;
  wire sck_fall = ~sck_s & sck_d_r;
  wire cs_end   = cs_s & ~cs_d_r;

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  reg                  busy_r;
  reg                  wpl_r;
  reg  [5:0]           nv_r;
  reg  [`OP_CNT_W-1:0] op_cnt_r;
  reg                  rst_arm_r;

  localparam [7:0] SR_RST = `SR_RESET;

  assign status_register    = {nv_r, wpl_r, busy_r};
  assign busy_flag          = busy_r;
  assign write_permit_latch = wpl_r;

  wire [3:0] prot_lvl = status_register[`SR_PL_MSB:`SR_PL_LSB];
  wire       qe       = status_register[`SR_QUAD_BIT];
  wire       lock     = status_register[`SR_LOCK_BIT];
  assign quad_pins_on = qe;

  // pins as data lines when quad set
  wire wp_low   = ~qe & ~wp_s;
  wire sr_locked = lock & wp_low;

  // select bit ignored in quad use
  wire ctl_pins = ~qe & ~quad_cmd_mode;
  assign hold_pause    = ctl_pins & ~hold_reset_select_bit & ~hold_s & ~cs_s;
  assign pin_reset_req = ctl_pins & hold_reset_select_bit & ~hold_s;

  // ----------------------------------------------------------------
  // Serial frame capture
  // ----------------------------------------------------------------
  reg [`CNT_W-1:0] bit_cnt_r;
  reg [31:0]       shift_r;
  reg [7:0]        cmd_r;
  reg [7:0]        wdata_r;
  reg [23:0]       addr_r;

  always @(posedge clk)
  begin
    if (srst)
    begin
      sck_d_r   <= 1'b0;
      cs_d_r    <= 1'b1;
      bit_cnt_r <= {`CNT_W{1'b0}};
      shift_r   <= 32'h0000_0000;
      cmd_r     <= 8'h00;
      wdata_r   <= 8'h00;
      addr_r    <= 24'h00_0000;
      so        <= 1'b0;
      so_oe     <= 1'b0;
    end
    else
    begin
      sck_d_r <= sck_s;
      cs_d_r  <= cs_s;
      if (cs_s)
      begin
        bit_cnt_r <= {`CNT_W{1'b0}};
        so_oe     <= 1'b0;
        if (!cs_end)
          cmd_r <= 8'h00;
      end
      else
      begin
        if (sck_rise)
        begin
          shift_r <= {shift_r[30:0], si_s};
          if (bit_cnt_r != `CNT_MAX)
            bit_cnt_r <= bit_cnt_r + 1'b1;
          if (bit_cnt_r == `CMD_LAST)
            cmd_r <= {shift_r[6:0], si_s};
          if (bit_cnt_r == `DATA_LAST)
            wdata_r <= {shift_r[6:0], si_s};
          if (bit_cnt_r == `ADDR_LAST)
            addr_r <= {shift_r[22:0], si_s};
        end
        // live status shifted out MSB first
        if (sck_fall && cmd_r == `CMD_STATUS_RD && bit_cnt_r >= `CMD_BITS)
        begin
          so    <= status_register[3'h7 - bit_cnt_r[2:0]];
          so_oe <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Protected region lookup
  // ----------------------------------------------------------------
  function prot_hit;
    input [3:0] lvl;
    input [3:0] blk;
    begin
      case (lvl)
        4'h0:    prot_hit = 1'b0;
        4'h1:    prot_hit = (blk >= 4'hf);
        4'h2:    prot_hit = (blk >= 4'he);
        4'h3:    prot_hit = (blk >= 4'hc);
        4'h4:    prot_hit = (blk >= 4'h8);
        4'hb:    prot_hit = (blk <= 4'h7);
        4'hc:    prot_hit = (blk <= 4'h3);
        4'hd:    prot_hit = (blk <= 4'h1);
        4'he:    prot_hit = (blk == 4'h0);
        4'hf:    prot_hit = 1'b0;
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Command decode at end of frame
  // ----------------------------------------------------------------
  wire len_cmd  = (bit_cnt_r == `CMD_BITS);
  wire len_data = (bit_cnt_r >= `WR_DATA_BITS);
  wire len_addr = (bit_cnt_r >= `ADDR_BITS);

  wire is_array = (cmd_r == `CMD_PAGE_PROG) || (cmd_r == `CMD_QPROG_A) ||
                  (cmd_r == `CMD_QPROG_B)   || (cmd_r == `CMD_SECT_ER_A) ||
                  (cmd_r == `CMD_SECT_ER_B) || (cmd_r == `CMD_BLK32_ER) ||
                  (cmd_r == `CMD_BLK64_ER);
  wire is_whole = (cmd_r == `CMD_ARRAY_ER_A) || (cmd_r == `CMD_ARRAY_ER_B);
  wire is_nvreg = (cmd_r == `CMD_FUNC_WR) || (cmd_r == `CMD_NV_RP) ||
                  (cmd_r == `CMD_NV_ERP)  || (cmd_r == `CMD_IR_ERASE) ||
                  (cmd_r == `CMD_IR_PROG) || (cmd_r == `CMD_BOOT_WR);

  wire in_prot = prot_hit(prot_lvl, addr_r[`BLK_MSB:`BLK_LSB]);

  wire go_array = wpl_r & is_array & len_addr & ~in_prot;
  // whole-array erase only with all protect bits clear
  wire go_whole = wpl_r & is_whole & len_cmd & (prot_lvl == 4'h0);
  wire go_nvreg = wpl_r & is_nvreg & len_cmd;
  wire go_sr    = wpl_r & (cmd_r == `CMD_STATUS_WR) & len_data & ~sr_locked;
  wire go_reset = rst_arm_r & (cmd_r == `CMD_RESET) & len_cmd;
  // volatile read settings fall through untouched
  wire start_op = go_array | go_whole | go_nvreg | go_sr;

  // ----------------------------------------------------------------
  // Status update, busy timer and array hand-off
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      busy_r         <= 1'b0;
      wpl_r          <= 1'b0;
      nv_r           <= SR_RST[`SR_NV_MSB:`SR_NV_LSB];
      op_cnt_r       <= {`OP_CNT_W{1'b0}};
      rst_arm_r      <= 1'b0;
      array_op_start <= 1'b0;
      array_op_code  <= 8'h00;
      array_op_addr  <= 24'h00_0000;
    end
    else
    begin
      array_op_start <= 1'b0;
      if (pin_reset_req || (cs_end && go_reset))
      begin
        busy_r    <= 1'b0;
        wpl_r     <= 1'b0;
        op_cnt_r  <= {`OP_CNT_W{1'b0}};
        rst_arm_r <= 1'b0;
      end
      else if (busy_r)
      begin
        // only reset is acted on here while busy
        if (cs_end)
          rst_arm_r <= (cmd_r == `CMD_RESET_EN) & len_cmd;
        // busy ends when the operation time runs out
        if (op_cnt_r == {`OP_CNT_W{1'b0}})
        begin
          busy_r <= 1'b0;
          wpl_r  <= 1'b0;
        end
        else
          op_cnt_r <= op_cnt_r - 1'b1;
      end
      else if (cs_end)
      begin
        rst_arm_r <= (cmd_r == `CMD_RESET_EN) & len_cmd;
        // latch changed only by its own commands
        if (cmd_r == `CMD_SET_WPL && len_cmd)
          wpl_r <= 1'b1;
        if (cmd_r == `CMD_CLR_WPL && len_cmd)
          wpl_r <= 1'b0;
        // data bits one and zero dropped
        if (go_sr)
          nv_r <= wdata_r[`SR_NV_MSB:`SR_NV_LSB];
        if (start_op)
        begin
          busy_r         <= 1'b1;
          op_cnt_r       <= OP_CYCLES - 1'b1;
          array_op_start <= 1'b1;
          array_op_code  <= cmd_r;
          array_op_addr  <= addr_r;
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/sync2.v ***
/*
  Two flip-flop synchroniser for a group of independent pin levels.
  Assumes each bit is a slow level or is oversampled by clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         srst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_r;

  always @(posedge clk)
  begin
    if (srst)
    begin
      meta_r <= {W{1'b1}};
      q      <= {W{1'b1}};
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

`default_nettype wire

// *** tb/flash_status_write_protect_monitor.sv ***
/* Concurrent checks on the status and write-permission block ports.
   Assumes one clock domain and binding to every instance. */
`timescale 1ns/1ps
`default_nettype none

module flash_status_monitor #(
  parameter [15:0] OP_CYCLES = 16'h1388
) (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       wp_n,
  input wire logic       hold_reset_select_bit,
  input wire logic       quad_cmd_mode,
  input wire logic [7:0] status_register,
  input wire logic       busy_flag,
  input wire logic       write_permit_latch,
  input wire logic       quad_pins_on,
  input wire logic       pin_reset_req,
  input wire logic       array_op_start,
  input wire logic [7:0] array_op_code
);
  logic [15:0] busy_cnt_r;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // ----
  // Busy length counter
  // ----
  always @(posedge clk)
    if (srst || !busy_flag)
      busy_cnt_r <= 16'h0000;
    else
      busy_cnt_r <= busy_cnt_r + 16'h0001;

  AST_MIRROR: assert property (status_register[1:0] == {write_permit_latch, busy_flag}
    && status_register[6] == quad_pins_on) else $error("status bits disagree with flags");
  AST_RST_ZERO: assert property ($past(srst) |-> status_register == 8'h00)
    else $error("status not zero after reset");
  AST_START_BUSY: assert property (array_op_start |-> busy_flag && !$past(busy_flag))
    else $error("operation started while busy");
  AST_BUSY_MAX: assert property (busy_cnt_r <= OP_CYCLES)
    else $error("busy held too long");
  AST_LATCH_FIRST: assert property (array_op_start |-> $past(write_permit_latch))
    else $error("operation started without latch");
  AST_AUTOCLR: assert property ($fell(busy_flag) |-> !write_permit_latch)
    else $error("latch not cleared at end of operation");
  AST_LATCH_HOLD: assert property (busy_flag && $past(busy_flag)
    |-> $stable(write_permit_latch)) else $error("latch changed while busy");
  AST_NV_CHANGE: assert property (!$past(srst) && !$stable(status_register[7:2])
    |-> array_op_start && array_op_code == 8'h01) else $error("protect bits changed");
  AST_ERASE_PROT: assert property (array_op_start && (array_op_code == 8'hc7
    || array_op_code == 8'h60) |-> $past(status_register[5:2]) == 4'h0)
    else $error("whole erase started with protection");
  // Pin level as the design saw it through its two sync stages
  AST_LOCK: assert property (array_op_start && array_op_code == 8'h01
    |-> !($past(status_register[7]) && !$past(status_register[6]) && !$past(wp_n, 3)))
    else $error("status write taken while locked");
  AST_PIN_RESET: assert property (pin_reset_req
    |-> hold_reset_select_bit && !quad_pins_on && !quad_cmd_mode)
    else $error("pin reset in wrong pin role");
  AST_PIN_RST_CLR: assert property (pin_reset_req
    |=> !busy_flag && !write_permit_latch)
    else $error("pin reset left busy or latch set");
endmodule

bind flash_status_write_protect flash_status_monitor #(.OP_CYCLES(OP_CYCLES)) mon (
  .clk(clk), .srst(srst), .wp_n(wp_n), .hold_reset_select_bit(hold_reset_select_bit),
  .quad_cmd_mode(quad_cmd_mode), .status_register(status_register),
  .busy_flag(busy_flag), .write_permit_latch(write_permit_latch),
  .quad_pins_on(quad_pins_on), .pin_reset_req(pin_reset_req),
  .array_op_start(array_op_start), .array_op_code(array_op_code));

`default_nettype wire

// *** tb/flash_status_write_protect_tb.sv ***
/* Self-checking bench for the status and write-permission block.
   Assumes the host model and the bound monitor beside it. */
`timescale 1ns/1ps
`default_nettype none

module flash_status_write_protect_tb;
  logic clk = 1'b0, srst, sck, cs_n, si, wp_n, hold_n, rsel, qmode;
  logic so, soe, busy, wpl, quad, prst, hold, start;
  logic [7:0] code, rx, starts = 8'h00;
  logic [23:0] addr;
  logic [31:0] dw;
  int miscompares = 0, check_count = 0, cyc = 0, k;
  logic [7:0] cmds [15] = '{8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7,
                            8'h60, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15};

  flash_status_write_protect #(.OP_CYCLES(16'h0320)) dut (
    .clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .hold_n(hold_n), .hold_reset_select_bit(rsel), .quad_cmd_mode(qmode), .so(so),
    .so_oe(soe), .status_register(), .busy_flag(busy), .write_permit_latch(wpl),
    .quad_pins_on(quad), .hold_pause(hold), .pin_reset_req(prst), .array_op_start(start),
    .array_op_code(code), .array_op_addr(addr));

  spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(soe));

  always @(posedge clk)
    if (start === 1'b1)
      starts <= starts + 8'h01;

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic send(input logic [31:0] d, input int n);
    host.xfer(d, n, rx);
  endtask

  task automatic wr_status(input logic [7:0] v);
    send(32'h00000006, 8);
    send({16'h0000, 8'h01, v}, 16);
  endtask

  task automatic rd_chk(input logic [7:0] exp);
    send(32'h00000500, 16);
    chk("status", exp, rx);
  endtask

  task automatic wait_idle;
    int t;
    for (t = 0; t < 2000 && busy !== 1'b0; t++)
      @(negedge clk);
    chk("busy", 8'h00, {7'h00, busy});
    @(negedge clk);
  endtask

  task automatic pins(input logic h, input logic r, input logic q);
    @(negedge clk);
    hold_n = h;
    rsel = r;
    qmode = q;
    repeat (4) @(negedge clk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      miscompares++;
      final_report;
    end
  end

  initial
  begin
    srst = 1'b1;
    wp_n = 1'b1;
    hold_n = 1'b1;
    rsel = 1'b0;
    qmode = 1'b0;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    rd_chk(8'h00);
    chk("so_oe", 8'h00, {7'h00, soe});
    send(32'h00000100, 16);
    chk("busy", 8'h00, {7'h00, busy});
    send(32'h00000006, 8);
    rd_chk(8'h02);
    send(32'h00000004, 8);
    rd_chk(8'h00);
    wr_status(8'h1f);
    send(32'h00000004, 8);
    rd_chk(8'h1f);
    wait_idle();
    rd_chk(8'h1c);
    wr_status(8'h04);
    wait_idle();
    send(32'h00000006, 8);
    send(32'h020f0000, 32);
    chk("busy", 8'h00, {7'h00, busy});
    send(32'h000000c7, 8);
    chk("busy", 8'h00, {7'h00, busy});
    send(32'h020e0000, 32);
    chk("addr", 8'h0e, addr[23:16]);
    wait_idle();
    wr_status(8'h00);
    wait_idle();
    for (k = 0; k < 15; k++)
    begin
      dw = (k < 7) ? {cmds[k], 24'h000000} : {24'h000000, cmds[k]};
      send(32'h00000006, 8);
      send(dw, (k < 7) ? 32 : 8);
      chk("code", cmds[k], code);
      wait_idle();
      chk("latch", 8'h00, {7'h00, wpl});
      send(dw, (k < 7) ? 32 : 8);
      chk("busy", 8'h00, {7'h00, busy});
    end
    wr_status(8'h80);
    wait_idle();
    wp_n = 1'b0;
    repeat (4) @(negedge clk);
    wr_status(8'h00);
    rd_chk(8'h82);
    wp_n = 1'b1;
    repeat (4) @(negedge clk);
    wr_status(8'h00);
    wait_idle();
    rd_chk(8'h00);
    pins(1'b0, 1'b1, 1'b0);
    chk("pin_reset", 8'h01, {7'h00, prst});
    pins(1'b0, 1'b1, 1'b1);
    chk("pin_reset", 8'h00, {7'h00, prst});
    pins(1'b0, 1'b0, 1'b0);
    fork
      send(32'h00000005, 8);
      begin
        #500;
        chk("hold_pause", 8'h01, {7'h00, hold});
      end
    join
    chk("hold_pause", 8'h00, {7'h00, hold});
    pins(1'b1, 1'b1, 1'b0);
    wr_status(8'h40);
    wait_idle();
    chk("quad", 8'h01, {7'h00, quad});
    pins(1'b0, 1'b1, 1'b0);
    chk("pin_reset", 8'h00, {7'h00, prst});
    pins(1'b1, 1'b1, 1'b0);
    wr_status(8'h40);
    chk("busy", 8'h01, {7'h00, busy});
    send(32'h00000066, 8);
    send(32'h00000099, 8);
    chk("busy", 8'h00, {7'h00, busy});
    chk("latch", 8'h00, {7'h00, wpl});
    chk("starts", 8'h17, starts);
    final_report;
  end
endmodule

`default_nettype wire

// *** tb/spi_host_model.sv ***
/* Behavioural SPI mode-0 host that frames flash instructions.
   Assumes the bench calls xfer and never overlaps two frames. */
`timescale 1ns/1ps
`default_nettype none

module spi_host_model #(
  parameter real HALF_NS = 62.5
) (
  output var logic sck,
  output var logic cs_n,
  output var logic si,
  input wire logic so,
  input wire logic so_oe
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end

  // ----
  // One frame of n bits MSB first; rx takes the second byte from so
  // ----
  task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] rx);
    int i;
    begin
      rx = 8'h00;
      cs_n = 1'b0;
      for (i = 0; i < n; i++)
      begin
        si = d[n-1-i];
        #(HALF_NS) sck = 1'b1;
        if (i >= 8 && i < 16)
          rx = {rx[6:0], so_oe ? so : ~so};
        #(HALF_NS) sck = 1'b0;
      end
      #(HALF_NS) cs_n = 1'b1;
      si = ~si;
      #(3*HALF_NS);
    end
  endtask
endmodule

`default_nettype wire
